// [core/scra_slave.sv]
// smbus word-read slave of a charger with overcurrent latches and status alert
// assumes scl_in/sda_in synchronous to clk; the sda wire is resolved outside from sda_oe_n
// Contract
// - read address acked only after repeated start with scl high under 50 us
// - after read address ack, send two bytes of the selected register
// - any start or stop aborts the transfer in progress at once
// - a lost host sends stop; the slave then returns to idle
// - while idle, all line activity is ignored until a start
// - address bytes other than own write/read address are not acked
// - reserved command code is nacked and not kept
// - reads need a valid command; data returned is that register
// - any status bit change raises the alert output
// - charge overcurrent bit latched and frozen until status is read
// - adapter overcurrent bit latched and frozen until status is read
// - own addresses are 0x12 for write and 0x13 for read
// - valid commands 0x12, 0x13, 0x14, 0x15, 0x3f; others reserved
// - alert rises 6 to 10 ms after a status bit toggles
`timescale 1ns/1ns
module scra_slave #(
    parameter int ALERT_DELAY_CYCLES = scra_pkg::ALERT_MIN_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // smbus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    // register contents from the charger core
    input  wire logic [15:0] mode_word,
    input  wire logic [15:0] charge_current_word,
    input  wire logic [15:0] charge_voltage_word,
    input  wire logic [15:0] input_current_word,
    input  wire logic [15:0] status_raw,
    // overcurrent detectors
    input  wire logic        charge_overcurrent_detect,
    input  wire logic        adapter_overcurrent_detect,
    // status and alert
    output logic [15:0]      status_word,
    output logic             alert
);

    scra_pkg::scra_slave_type r_reg;
    scra_pkg::scra_slave_type r_next;

    logic       start_evt;
    logic       stop_evt;
    logic       scl_rise;
    logic       scl_fall;
    logic [7:0] rx_byte;
    logic [1:0] oc_detect;
    logic       status_change;

    function automatic logic [15:0] reg_select(input logic [7:0] code);
        case (code)
            scra_pkg::CMD_MODE:          reg_select = mode_word;
            scra_pkg::CMD_STATUS:        reg_select = r_reg.status;
            scra_pkg::CMD_CHG_CURRENT:   reg_select = charge_current_word;
            scra_pkg::CMD_CHG_VOLTAGE:   reg_select = charge_voltage_word;
            scra_pkg::CMD_INPUT_CURRENT: reg_select = input_current_word;
            default:                     reg_select = 16'h0000;
        endcase
    endfunction

    // sda only changes while scl is low, except for start and stop
    assign start_evt = r_reg.scl_d && scl_in && r_reg.sda_d && !sda_in;
    assign stop_evt  = r_reg.scl_d && scl_in && !r_reg.sda_d && sda_in;
    assign scl_rise  = !r_reg.scl_d && scl_in;
    assign scl_fall  = r_reg.scl_d && !scl_in;
    assign rx_byte   = {r_reg.shreg[6:0], sda_in};
    assign oc_detect = {adapter_overcurrent_detect, charge_overcurrent_detect};

    always_comb begin
        r_next            = r_reg;
        r_next.scl_d      = scl_in;
        r_next.sda_d      = sda_in;
        r_next.read_clear = 1'b0;

        if (scl_in) begin
            if (r_reg.hi_cnt != '1) begin
                r_next.hi_cnt = r_reg.hi_cnt + 1'b1;
            end
        end else begin
            r_next.hi_cnt = '0;
        end

        if (stop_evt) begin
            r_next.phase     = scra_pkg::ST_IDLE;
            r_next.drive     = 1'b0;
            r_next.cmd_valid = 1'b0;
            r_next.rs_pending = 1'b0;
        end else if (start_evt) begin
            // repeated start qualified by scl high time
            r_next.rs_pending = (r_reg.phase == scra_pkg::ST_WAIT_RS) && r_reg.cmd_valid
                && (r_reg.hi_cnt < scra_pkg::HI_CNT_W'(scra_pkg::RS_HIGH_MAX_CYCLES));
            if (!r_next.rs_pending) begin
                r_next.cmd_valid = 1'b0;
            end
            r_next.phase   = scra_pkg::ST_ADDR;
            r_next.drive   = 1'b0;
            r_next.bitcnt  = '0;
            r_next.hi_byte = 1'b0;
        end else begin
            case (r_reg.phase)
                scra_pkg::ST_IDLE: begin
                    r_next.drive = 1'b0;
                end
                scra_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        r_next.shreg  = rx_byte;
                        r_next.bitcnt = r_reg.bitcnt + 1'b1;
                        if (r_reg.bitcnt == scra_pkg::BIT_LAST) begin
                            r_next.phase    = scra_pkg::ST_ACK;
                            r_next.ack_half = 1'b0;
                            if (rx_byte == scra_pkg::WR_ADDR) begin
                                r_next.do_ack     = 1'b1;
                                r_next.ack_tgt    = scra_pkg::ST_CMD;
                                r_next.cmd_valid  = 1'b0;
                                r_next.rs_pending = 1'b0;
                            end else if (rx_byte == scra_pkg::RD_ADDR && r_reg.rs_pending) begin
                                r_next.do_ack  = 1'b1;
                                r_next.ack_tgt = scra_pkg::ST_TX;
                                r_next.tx_word = reg_select(r_reg.cmd);
                            end else begin
                                r_next.do_ack  = 1'b0;
                                r_next.ack_tgt = scra_pkg::ST_IGNORE;
                            end
                        end
                    end
                end
                scra_pkg::ST_CMD: begin
                    if (scl_rise) begin
                        r_next.shreg  = rx_byte;
                        r_next.bitcnt = r_reg.bitcnt + 1'b1;
                        if (r_reg.bitcnt == scra_pkg::BIT_LAST) begin
                            r_next.phase     = scra_pkg::ST_ACK;
                            r_next.ack_half  = 1'b0;
                            r_next.do_ack    = scra_pkg::cmd_is_valid(rx_byte);
                            r_next.cmd_valid = r_next.do_ack;
                            r_next.ack_tgt   = r_next.do_ack ? scra_pkg::ST_WAIT_RS
                                                             : scra_pkg::ST_IGNORE;
                            if (r_next.do_ack) begin
                                r_next.cmd = rx_byte;
                            end
                        end
                    end
                end
                scra_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (!r_reg.ack_half) begin
                            r_next.ack_half = 1'b1;
                            r_next.drive    = r_reg.do_ack;
                        end else if (r_reg.do_ack && r_reg.ack_tgt == scra_pkg::ST_TX) begin
                            r_next.phase  = scra_pkg::ST_TX;
                            r_next.shreg  = r_reg.tx_word[7:0];
                            r_next.drive  = !r_reg.tx_word[7];
                            r_next.bitcnt = '0;
                        end else begin
                            r_next.phase  = r_reg.do_ack ? r_reg.ack_tgt : scra_pkg::ST_IGNORE;
                            r_next.drive  = 1'b0;
                            r_next.bitcnt = '0;
                        end
                    end
                end
                scra_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (r_reg.bitcnt == scra_pkg::BIT_LAST) begin
                            r_next.drive    = 1'b0;
                            r_next.phase    = scra_pkg::ST_HACK;
                            r_next.host_ack = 1'b0;
                        end else begin
                            r_next.shreg  = {r_reg.shreg[6:0], 1'b0};
                            r_next.drive  = !r_reg.shreg[6];
                            r_next.bitcnt = r_reg.bitcnt + 1'b1;
                        end
                    end
                end
                scra_pkg::ST_HACK: begin
                    if (scl_rise) begin
                        r_next.host_ack = !sda_in;
                        if (r_reg.hi_byte) begin
                            // second byte shipped: a status read releases the latches
                            r_next.phase      = scra_pkg::ST_IGNORE;
                            r_next.read_clear = (r_reg.cmd == scra_pkg::CMD_STATUS);
                        end
                    end else if (scl_fall) begin
                        if (r_reg.host_ack && !r_reg.hi_byte) begin
                            r_next.hi_byte = 1'b1;
                            r_next.phase   = scra_pkg::ST_TX;
                            r_next.shreg   = r_reg.tx_word[15:8];
                            r_next.drive   = !r_reg.tx_word[15];
                            r_next.bitcnt  = '0;
                        end else begin
                            r_next.phase = scra_pkg::ST_IGNORE;
                        end
                    end
                end
                scra_pkg::ST_WAIT_RS, scra_pkg::ST_IGNORE: begin
                    r_next.drive = 1'b0;
                end
                default: begin
                    r_next.phase = scra_pkg::ST_IDLE;
                    r_next.drive = 1'b0;
                end
            endcase
        end

        // latch and freeze; a detection beats a same-cycle clear
        for (int i = 0; i < 2; i++) begin
            r_next.oc_flag[i] = oc_detect[i] || (r_reg.oc_flag[i] && !r_reg.read_clear);
        end
        r_next.status = status_raw;
        for (int i = 0; i < 2; i++) begin
            r_next.status[scra_pkg::STATUS_OC_BIT[i]] = r_reg.oc_flag[i];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg        <= '0;
            r_reg.phase  <= scra_pkg::ST_IDLE;
            r_reg.scl_d  <= 1'b1;
            r_reg.sda_d  <= 1'b1;
            r_reg.status <= scra_pkg::STATUS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // any toggle of the status word
    assign status_change = (r_next.status != r_reg.status);

    scra_alert_timer #(
        .DELAY_CYCLES (ALERT_DELAY_CYCLES)
    ) u_alert (
        .clk    (clk),
        .reset  (reset),
        .change (status_change),
        .clear  (r_reg.read_clear),
        .alert  (alert)
    );

    assign sda_out     = 1'b0;
    assign sda_oe_n    = !r_reg.drive;
    assign status_word = r_reg.status;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_read_needs_rs: assert property (
        r_reg.phase == scra_pkg::ST_ACK && r_reg.ack_tgt == scra_pkg::ST_TX && r_reg.do_ack
        |-> r_reg.rs_pending && r_reg.cmd_valid)
        else $error("read address acked without qualified repeated start");

    chk_addr_match: assert property (
        r_reg.phase == scra_pkg::ST_ACK && r_reg.do_ack && r_reg.ack_tgt != scra_pkg::ST_WAIT_RS
        |-> r_reg.shreg == scra_pkg::WR_ADDR || r_reg.shreg == scra_pkg::RD_ADDR)
        else $error("foreign address byte acked");

    chk_cmd_kept_valid: assert property (
        r_reg.cmd_valid |-> scra_pkg::cmd_is_valid(r_reg.cmd))
        else $error("reserved command code retained");

    chk_stop_idle: assert property (
        stop_evt |=> r_reg.phase == scra_pkg::ST_IDLE && sda_oe_n)
        else $error("stop did not return to idle");

    chk_start_abort: assert property (
        start_evt && !stop_evt |=> r_reg.phase == scra_pkg::ST_ADDR && sda_oe_n)
        else $error("start did not abort the transfer");

    chk_idle_quiet: assert property (
        r_reg.phase == scra_pkg::ST_IDLE && !start_evt |=> r_reg.phase == scra_pkg::ST_IDLE
        && sda_oe_n)
        else $error("idle slave reacted to line activity");

    chk_first_byte: assert property (
        r_reg.phase == scra_pkg::ST_TX && $past(r_reg.phase) == scra_pkg::ST_ACK
        |-> r_reg.shreg == r_reg.tx_word[7:0] && sda_oe_n == r_reg.tx_word[7])
        else $error("first data byte not from the selected register");

    chk_chg_latch: assert property (
        r_reg.oc_flag[scra_pkg::OC_CHARGE] && !r_reg.read_clear
        |=> r_reg.oc_flag[scra_pkg::OC_CHARGE] ##1
            r_reg.status[scra_pkg::STATUS_OC_BIT[scra_pkg::OC_CHARGE]])
        else $error("charge overcurrent latch lost before status read");

    chk_ada_latch: assert property (
        adapter_overcurrent_detect |=> r_reg.oc_flag[scra_pkg::OC_ADAPTER])
        else $error("adapter overcurrent not latched");

    cov_word_read: cover property (r_reg.phase == scra_pkg::ST_HACK && r_reg.hi_byte
        ##1 r_reg.phase == scra_pkg::ST_IGNORE);
    cov_reserved_cmd: cover property (r_reg.phase == scra_pkg::ST_ACK && !r_reg.do_ack
        && r_reg.ack_tgt == scra_pkg::ST_IGNORE && r_reg.ack_half);
    cov_status_clear: cover property (r_reg.read_clear && r_reg.oc_flag != 2'h0);

endmodule

// [common/scra_pkg.sv]
// constants, state layouts and command decode for the charger smbus read/alert slave
// assumes a single 25 MHz clock; scl and sda arrive already synchronous to it
package scra_pkg;

    // clock and timing
    localparam int CLK_HZ             = 25_000_000;
    localparam int RS_HIGH_MAX_US     = 50;
    // longest time: rounds down
    localparam int RS_HIGH_MAX_CYCLES = (RS_HIGH_MAX_US * CLK_HZ) / 1_000_000;
    localparam int ALERT_MIN_MS       = 6;
    localparam int ALERT_MAX_MS       = 10;
    // least and longest time both round down through CLK_HZ / 1000
    localparam int ALERT_MIN_CYCLES   = (ALERT_MIN_MS * (CLK_HZ / 1000) * 1 + 0);
    localparam int ALERT_MAX_CYCLES   = (ALERT_MAX_MS * (CLK_HZ / 1000));
    localparam int HI_CNT_W           = 11;
    localparam int ALERT_CNT_W        = 18;

    // bus addresses and command codes
    localparam logic [7:0] WR_ADDR           = 8'h12;
    localparam logic [7:0] RD_ADDR           = 8'h13;
    localparam logic [7:0] CMD_MODE          = 8'h12;
    localparam logic [7:0] CMD_STATUS        = 8'h13;
    localparam logic [7:0] CMD_CHG_CURRENT   = 8'h14;
    localparam logic [7:0] CMD_CHG_VOLTAGE   = 8'h15;
    localparam logic [7:0] CMD_INPUT_CURRENT = 8'h3f;

    // status word layout
    localparam logic [15:0] STATUS_RESET  = 16'h0000;
    localparam int          OC_CHARGE     = 0;
    localparam int          OC_ADAPTER    = 1;
    localparam int          STATUS_OC_BIT [2] = '{4, 5};
    localparam logic [2:0]  BIT_LAST      = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_ADDR    = 3'h1,
        ST_ACK     = 3'h3,
        ST_CMD     = 3'h2,
        ST_WAIT_RS = 3'h6,
        ST_TX      = 3'h7,
        ST_HACK    = 3'h5,
        ST_IGNORE  = 3'h4
    } scra_phase_type;

    typedef struct packed {
        scra_phase_type        phase;
        scra_phase_type        ack_tgt;
        logic                  do_ack;
        logic                  ack_half;
        logic [7:0]            shreg;
        logic [2:0]            bitcnt;
        logic [7:0]            cmd;
        logic                  cmd_valid;
        logic                  rs_pending;
        logic                  hi_byte;
        logic                  host_ack;
        logic [15:0]           tx_word;
        logic                  drive;
        logic                  scl_d;
        logic                  sda_d;
        logic [HI_CNT_W-1:0]   hi_cnt;
        logic [1:0]            oc_flag;
        logic [15:0]           status;
        logic                  read_clear;
    } scra_slave_type;

    typedef struct packed {
        logic                   counting;
        logic [ALERT_CNT_W-1:0] cnt;
        logic                   alert;
    } scra_alert_type;

    function automatic logic cmd_is_valid(input logic [7:0] code);
        case (code)
            CMD_MODE, CMD_STATUS, CMD_CHG_CURRENT,
            CMD_CHG_VOLTAGE, CMD_INPUT_CURRENT: cmd_is_valid = 1'b1;
            default:                            cmd_is_valid = 1'b0;
        endcase
    endfunction

endpackage

// [core/scra_alert_timer.sv]
// delays a status change by a fixed count before raising the alert level
// assumes change and clear are one-cycle pulses from the slave in the same clock domain
`timescale 1ns/1ns
module scra_alert_timer #(
    parameter int DELAY_CYCLES = scra_pkg::ALERT_MIN_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // events
    input  wire logic change,
    input  wire logic clear,
    // alert level
    output logic      alert
);

    scra_pkg::scra_alert_type r_reg;
    scra_pkg::scra_alert_type r_next;

    localparam logic [scra_pkg::ALERT_CNT_W-1:0] CNT_LAST =
        scra_pkg::ALERT_CNT_W'(DELAY_CYCLES - 1);

    always_comb begin
        r_next = r_reg;
        if (clear) begin
            r_next.alert = 1'b0;
        end
        if (r_reg.counting) begin
            if (r_reg.cnt == CNT_LAST) begin
                r_next.counting = 1'b0;
                r_next.alert    = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt + 1'b1;
            end
        end else if (change && !r_next.alert) begin
            r_next.counting = 1'b1;
            r_next.cnt      = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign alert = r_reg.alert;

    chk_alert_delay: assert property (@(posedge clk) disable iff (reset)
        $rose(alert) |-> $past(r_reg.cnt) == CNT_LAST && $past(r_reg.counting))
        else $error("alert rose before the delay count ran out");

    chk_alert_window: assert property (@(posedge clk) disable iff (reset)
        r_reg.counting |-> r_reg.cnt < scra_pkg::ALERT_CNT_W'(scra_pkg::ALERT_MAX_CYCLES))
        else $error("alert delay exceeds the longest allowed time");

    chk_alert_arm: assert property (@(posedge clk) disable iff (reset)
        change && !alert && !r_reg.counting |=> r_reg.counting && r_reg.cnt == '0)
        else $error("status change did not start the alert delay");

    cov_alert_rise: cover property (@(posedge clk) disable iff (reset) $rose(alert));

endmodule

// [verif/scra_host.sv]
// smbus host model: drives scl and sda (1 = released), samples the resolved line
// assumes the bench resolves sda_line from all drivers with a pull-up
`timescale 1ns/1ns
module scra_host #(
    parameter int HALF = 4
) (
    // clock
    input  wire logic clk,
    // smbus
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    // hi sets how long scl stays high before sda falls (repeated start qualification)
    task automatic start(input int hi);
        sda = 1'b1;
        wait_n(HALF);
        scl = 1'b1;
        wait_n(hi);
        sda = 1'b0;
        wait_n(HALF);
        scl = 1'b0;
    endtask

    // stop also recovers a lost transfer
    task automatic stop();
        sda = 1'b0;
        wait_n(HALF);
        scl = 1'b1;
        wait_n(HALF);
        sda = 1'b1;
        wait_n(HALF);
    endtask

    // sampling at the end of the high phase gives the slave the whole half to settle
    task automatic bit_io(input logic b, output logic r);
        sda = b;
        wait_n(HALF);
        scl = 1'b1;
        wait_n(HALF);
        r = sda_line;
        scl = 1'b0;
        wait_n(1);
    endtask

    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic ar);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(a, ar);
    endtask

    // clocks a byte with no start before it; an idle slave must not answer
    task automatic loose_byte(input logic [7:0] d, output logic ar);
        logic [7:0] q;
        scl = 1'b0;
        wait_n(HALF);
        xfer(d, 1'b1, q, ar);
    endtask

    // every read starts over from the write address
    task automatic read_word(input logic [7:0] cmd, input int hi, output logic [15:0] w,
                             output logic [2:0] acks);
        logic [7:0] q;
        logic       x;
        start(HALF);
        xfer(scra_pkg::WR_ADDR, 1'b1, q, acks[2]);
        xfer(cmd, 1'b1, q, acks[1]);
        start(hi);
        xfer(scra_pkg::RD_ADDR, 1'b1, q, acks[0]);
        // ack the low byte, nack the high byte
        xfer(8'hff, 1'b0, w[7:0], x);
        xfer(8'hff, 1'b1, w[15:8], x);
        stop();
    endtask
endmodule

// [verif/smbus_charger_read_alarm_tb.sv]
// self-checking bench of the charger smbus read/alert slave
// assumes scra_host as the bus master and a pull-up on sda
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
    $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module smbus_charger_read_alarm_tb;
    localparam int D = 20;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        scl;
    logic        h_sda;
    wire logic   sda_line;
    logic        sda_out;
    logic        sda_oe_n;
    logic [15:0] words [5] = '{16'h1234, 16'ha5c3, 16'h0bcd, 16'h4e5f, 16'h7a81};
    logic        chg_det = 1'b0;
    logic        ada_det = 1'b0;
    logic [15:0] status_word;
    logic        alert;
    int          errors = 0;
    int          n_tests = 0;

    always #20 clk = ~clk;
    assign sda_line = h_sda & (sda_oe_n | sda_out);

    scra_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(h_sda));
    scra_slave #(.ALERT_DELAY_CYCLES(D)) DUT (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .mode_word(words[0]), .charge_current_word(words[2]),
        .charge_voltage_word(words[3]), .input_current_word(words[4]),
        .status_raw(words[1]), .charge_overcurrent_detect(chg_det),
        .adapter_overcurrent_detect(ada_det), .status_word(status_word), .alert(alert));

    task automatic complete_run();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic t_reads();
        logic [15:0] w;
        logic [2:0]  a;
        logic [7:0]  cmds [5];
        cmds = '{scra_pkg::CMD_MODE, scra_pkg::CMD_STATUS, scra_pkg::CMD_CHG_CURRENT,
                 scra_pkg::CMD_CHG_VOLTAGE, scra_pkg::CMD_INPUT_CURRENT};
        // second pass on inverted contents so every register bit except status bits 5:4 is seen both ways
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 5; i++) begin
                host.read_word(cmds[i], 4, w, a);
                `CHK(a, 3'h0)
                `CHK(w, words[i] & 16'hffcf | words[i] & 16'h0030 & {16{i != 1}})
            end
            for (int j = 0; j < 5; j++) begin
                words[j] = ~words[j];
            end
        end
        $display("done reads");
    endtask

    task automatic t_refuse();
        logic [15:0] w;
        logic [2:0]  a;
        logic [7:0]  q;
        logic        x;
        host.read_word(8'h16, 4, w, a);
        `CHK(a, 3'b011)
        `CHK(w, 16'hffff)
        host.start(4);
        host.xfer(8'h20, 1'b1, q, x);
        `CHK(x, 1'b1)
        host.stop();
        host.loose_byte(scra_pkg::WR_ADDR, x);
        `CHK(x, 1'b1)
        host.start(4);
        host.xfer(scra_pkg::RD_ADDR, 1'b1, q, x);
        `CHK(x, 1'b1)
        host.stop();
        host.read_word(scra_pkg::CMD_MODE, 1300, w, a);
        `CHK(a, 3'b001)
        host.read_word(scra_pkg::CMD_MODE, 1200, w, a);
        `CHK({a, w}, {3'h0, words[0]})
        $display("done refuse");
    endtask

    task automatic t_abort();
        logic [15:0] w;
        logic [2:0]  a;
        logic [7:0]  q;
        logic        x;
        logic [2:0]  r;
        host.start(4);
        host.xfer(scra_pkg::WR_ADDR, 1'b1, q, x);
        host.xfer(scra_pkg::CMD_MODE, 1'b1, q, x);
        host.stop();
        host.start(4);
        host.xfer(scra_pkg::RD_ADDR, 1'b1, q, x);
        `CHK(x, 1'b1)
        host.stop();
        host.start(4);
        host.xfer(scra_pkg::WR_ADDR, 1'b1, q, x);
        host.xfer(scra_pkg::CMD_MODE, 1'b1, q, x);
        host.start(4);
        host.xfer(scra_pkg::RD_ADDR, 1'b1, q, x);
        // start inside the low byte where the slave releases sda, else no start is visible
        host.bit_io(1'b1, r[2]);
        host.bit_io(1'b1, r[1]);
        host.bit_io(1'b1, r[0]);
        `CHK(r, words[0][7:5])
        host.start(4);
        host.xfer(scra_pkg::RD_ADDR, 1'b1, q, x);
        `CHK(x, 1'b1)
        host.stop();
        host.read_word(scra_pkg::CMD_MODE, 4, w, a);
        `CHK(w, words[0])
        $display("done abort");
    endtask

    task automatic t_latch();
        logic [15:0] w;
        logic [2:0]  a;
        chg_det = 1'b1;
        host.wait_n(1);
        chg_det = 1'b0;
        host.wait_n(4);
        `CHK(status_word[5:4], 2'b01)
        ada_det = 1'b1;
        host.wait_n(1);
        ada_det = 1'b0;
        host.wait_n(4);
        `CHK(status_word[5:4], 2'b11)
        host.read_word(scra_pkg::CMD_STATUS, 4, w, a);
        `CHK(w[5:4], 2'b11)
        host.wait_n(4);
        `CHK(status_word[5:4], 2'b00)
        $display("done latch");
    endtask

    task automatic t_alert();
        logic [15:0] w;
        logic [2:0]  a;
        int          n;
        host.wait_n(3 * D);
        host.read_word(scra_pkg::CMD_STATUS, 4, w, a);
        host.wait_n(3);
        `CHK(alert, 1'b0)
        words[1] = words[1] ^ 16'h0001;
        n = 0;
        while (alert !== 1'b1) begin
            host.wait_n(1);
            n++;
            if (n > 10 * D) begin
                errors++;
                complete_run();
            end
        end
        `CHK(n >= D && n <= D + 3, 1'b1)
        host.read_word(scra_pkg::CMD_STATUS, 4, w, a);
        host.wait_n(3);
        `CHK(alert, 1'b0)
        $display("done alert");
    endtask

    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        host.wait_n(2);
        t_reads();
        t_refuse();
        t_abort();
        t_latch();
        t_alert();
        complete_run();
    end
endmodule
